/* rtl/usb_ep_port.sv */
// The register offsets and the Wishbone register port are this design's own decisions.
module usb_ep_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic tx_pop,
  output logic [7:0] tx_data,
  output logic tx_packet_ready,
  input wire logic tx_done,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic transceiver_off,
  output logic pullup_connect,
  output logic bus_reset
);
  ////////////////////////////////////////////////////////////////////////
  usb_ep_fifo_if fi ();
  usb_ep_fifo u_fifo (
    .clk(clk),
    .reset(reset),
    .f(fi.store)
  );

  logic [1:0] txvc_r;
  logic rx_bank0_full_r;
  logic tx_rdy_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic dp_s1_r, dp_s2_r, dm_s1_r, dm_s2_r;
  logic se0_r;
  logic access;
  logic wr;
  logic rd;
  logic wr_csr;
  logic rx_in;

  ////////////////////////////////////////////////////////////////////////
  // wishbone: single-cycle-latency ack, dropped the cycle after
  assign access = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = access && wb_we_i && wb_sel_i[0];
  assign rd = access && !wb_we_i;
  assign wr_csr = wr && (wb_adr_i == usb_ep_pkg::off_csr);
  // host bytes only land while bank 0 is owned by the device
  assign rx_in = rx_valid && !rx_bank0_full_r;

  always_comb begin
    fi.push = rx_in || (wr && (wb_adr_i == usb_ep_pkg::off_fifo) && !tx_rdy_r);
    fi.wdata = rx_in ? rx_data : wb_dat_i[7:0];
    fi.pop = (rd && (wb_adr_i == usb_ep_pkg::off_fifo)) || tx_pop;
    fi.clear = bus_reset;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dat_r <= '0;
    end else if (rd) begin
      case (wb_adr_i)
        usb_ep_pkg::off_fifo: dat_r <= {24'h000000, fi.rdata};
        usb_ep_pkg::off_csr: begin
          dat_r <= '0;
          dat_r[usb_ep_pkg::cnt_lsb +: usb_ep_pkg::cnt_w] <= fi.count;
          dat_r[usb_ep_pkg::bit_rx_bk0] <= rx_bank0_full_r;
          dat_r[usb_ep_pkg::bit_tx_rdy] <= tx_rdy_r;
        end
        usb_ep_pkg::off_txvc: begin
          dat_r <= '0;
          dat_r[usb_ep_pkg::bit_txv_off] <= txvc_r[0];
          dat_r[usb_ep_pkg::bit_pullup] <= txvc_r[1];
        end
        default: dat_r <= '0;
      endcase
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////
  // transceiver control
  always_ff @(posedge clk) begin
    if (reset) begin
      txvc_r <= usb_ep_pkg::txvc_reset;
    end else if (wr && (wb_adr_i == usb_ep_pkg::off_txvc) && wb_sel_i[1]) begin
      txvc_r[0] <= wb_dat_i[usb_ep_pkg::bit_txv_off];
      txvc_r[1] <= wb_dat_i[usb_ep_pkg::bit_pullup];
    end
  end
  assign transceiver_off = txvc_r[0];
  assign pullup_connect = txvc_r[1];

  ////////////////////////////////////////////////////////////////////////
  // line state synchronisers and se0 detect
  always_ff @(posedge clk) begin
    if (reset) begin
      // idle j state has d+ high: a low reset value would fake se0 after reset
      dp_s1_r <= 1'b1;
      dp_s2_r <= 1'b1;
      dm_s1_r <= 1'b0;
      dm_s2_r <= 1'b0;
    end else begin
      dp_s1_r <= dp_in;
      dp_s2_r <= dp_s1_r;
      dm_s1_r <= dm_in;
      dm_s2_r <= dm_s1_r;
    end
  end

  // registered so bus_reset is a clean level; held while se0 stands
  always_ff @(posedge clk) begin
    if (reset) begin
      se0_r <= 1'b0;
    end else begin
      se0_r <= !dp_s2_r && !dm_s2_r;
    end
  end
  assign bus_reset = se0_r;

  ////////////////////////////////////////////////////////////////////////
  // endpoint flags: hardware wins over firmware (rx_end set beats firmware clear while bank 0 is empty, tx_done clear beats firmware set)
  always_ff @(posedge clk) begin
    if (reset || bus_reset) begin
      rx_bank0_full_r <= 1'b0;
    end else if (rx_end && !rx_bank0_full_r) begin
      rx_bank0_full_r <= 1'b1;
    end else if (wr_csr && !wb_dat_i[usb_ep_pkg::bit_rx_bk0]) begin
      rx_bank0_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || bus_reset) begin
      tx_rdy_r <= 1'b0;
    end else if (tx_done) begin
      tx_rdy_r <= 1'b0;
    end else if (wr_csr && wb_dat_i[usb_ep_pkg::bit_tx_rdy]) begin
      tx_rdy_r <= 1'b1;
    end
  end
  assign tx_packet_ready = tx_rdy_r;
  assign tx_data = fi.rdata;

  ////////////////////////////////////////////////////////////////////////
  property p_bk0_set;
    @(posedge clk) disable iff (reset)
      rx_end && !rx_bank0_full_r && !bus_reset |=> rx_bank0_full_r;
  endproperty
  a_bk0_set: assert property (p_bk0_set) else $error("bank0 flag not set");

  property p_txv;
    @(posedge clk) disable iff (reset)
      wr && wb_adr_i == usb_ep_pkg::off_txvc && wb_sel_i[1]
      |=> transceiver_off == $past(wb_dat_i[usb_ep_pkg::bit_txv_off]);
  endproperty
  a_txv: assert property (p_txv) else $error("transceiver_off wrong");

  property p_pu;
    @(posedge clk) disable iff (reset)
      wr && wb_adr_i == usb_ep_pkg::off_txvc && wb_sel_i[1]
      |=> pullup_connect == $past(wb_dat_i[usb_ep_pkg::bit_pullup]);
  endproperty
  a_pu: assert property (p_pu) else $error("pullup_connect wrong");

  sequence s_se0;
    (!dp_in && !dm_in) [*4];
  endsequence
  property p_se0;
    @(posedge clk) disable iff (reset) s_se0 |-> bus_reset;
  endproperty
  a_se0: assert property (p_se0) else $error("se0 not seen");

  property p_cnt;
    @(posedge clk) disable iff (reset)
      rd && wb_adr_i == usb_ep_pkg::off_fifo && !fi.empty && !fi.push && !bus_reset
      |=> fi.count == $past(fi.count) - usb_ep_pkg::cnt_one;
  endproperty
  a_cnt: assert property (p_cnt) else $error("pop did not drop count");

  // a host byte that is taken must show in the count one cycle later
  property p_rx_push;
    @(posedge clk) disable iff (reset)
      rx_in && !fi.full && !fi.pop && !bus_reset
      |=> fi.count == $past(fi.count) + usb_ep_pkg::cnt_one;
  endproperty
  a_rx_push: assert property (p_rx_push) else $error("rx byte not counted");

  property p_bus_rst;
    @(posedge clk) disable iff (reset)
      bus_reset |=> fi.empty && !rx_bank0_full_r && !tx_rdy_r;
  endproperty
  a_bus_rst: assert property (p_bus_rst) else $error("bus reset left state");

  // one access, one ack pulse; the ack itself blocks a second take
  sequence s_wb_take;
    access;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    @(posedge clk) disable iff (reset) s_wb_take |=> s_ack_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");

  property p_tx_done;
    @(posedge clk) disable iff (reset) tx_done |=> !tx_packet_ready;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx ready not cleared");

  // a payload already handed over must not grow from firmware writes
  property p_wr_refused;
    @(posedge clk) disable iff (reset)
      wr && wb_adr_i == usb_ep_pkg::off_fifo && tx_rdy_r && !rx_in && !fi.pop && !bus_reset
      |=> fi.count == $past(fi.count);
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("fifo write not refused");
endmodule // usb_ep_port

/* rtl/usb_ep_pkg.sv */
// Operation
// - rx_byte_count, eleven bits, read-only, counts received bytes held in fifo.
// - received packet bytes enter the fifo, then rx_bank0_full tells firmware.
// - fifo port read pops byte into bits 7:0; write pushes bits 7:0; dropped here while tx_packet_ready is set or a host byte lands that cycle.
// - transceiver_off bit 8 powers transceiver down; clearing re-enables it.
// - pullup_connect bit 9: 0 disconnects, 1 connects the 1.5k d+ pull-up.
// - both data lines low means single-ended zero: perform a usb bus reset.
package usb_ep_pkg;
  localparam int fifo_depth = 64;
  localparam int ptr_w = 6;
  localparam int cnt_w = 11;
  localparam logic [7:0] off_fifo = 8'h00;
  localparam logic [7:0] off_csr = 8'h04;
  localparam logic [7:0] off_txvc = 8'h08;
  localparam int bit_txv_off = 8;
  localparam int bit_pullup = 9;
  localparam int bit_rx_bk0 = 1;
  localparam int bit_tx_rdy = 4;
  localparam int cnt_lsb = 16;
  localparam logic [cnt_w-1:0] cnt_zero = 11'h000;
  localparam logic [cnt_w-1:0] cnt_one = 11'h001;
  localparam logic [1:0] txvc_reset = 2'h0;
endpackage

/* rtl/usb_ep_fifo_if.sv */
interface usb_ep_fifo_if;
  logic push;
  logic pop;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [10:0] count;
  logic full;
  logic empty;
  logic clear;
  modport ctrl (output push, output pop, output wdata, output clear,
    input rdata, input count, input full, input empty);
  modport store (input push, input pop, input wdata, input clear,
    output rdata, output count, output full, output empty);
endinterface

/* rtl/usb_ep_fifo.sv */
module usb_ep_fifo (
  input wire logic clk,
  input wire logic reset,
  usb_ep_fifo_if.store f
);
  logic [7:0] mem_r [usb_ep_pkg::fifo_depth];
  logic [usb_ep_pkg::ptr_w-1:0] wp_r;
  logic [usb_ep_pkg::ptr_w-1:0] rp_r;
  logic [10:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign f.full = (cnt_r == 11'(usb_ep_pkg::fifo_depth));
  assign f.empty = (cnt_r == usb_ep_pkg::cnt_zero);
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;
  assign f.rdata = mem_r[rp_r];
  assign f.count = cnt_r;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wp_r] <= f.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || f.clear) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= usb_ep_pkg::cnt_zero;
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 1'b1;
      end
      // count of bytes held, read back by firmware
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + usb_ep_pkg::cnt_one;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - usb_ep_pkg::cnt_one;
      end
    end
  end
endmodule // usb_ep_fifo

/* dv/usb_host_model.sv */
module usb_host_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic tx_pop,
  output logic tx_done,
  output logic dp_in,
  output logic dm_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    tx_pop = 1'b0;
    tx_done = 1'b0;
    dp_in = 1'b1;
    dm_in = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b; // no stale byte left between pulses
  endtask
  // 0 ends a packet, 1 takes a tx byte, 2 acknowledges the IN data
  task automatic pulse(input int kind);
    @(posedge clk);
    rx_end <= (kind == 0);
    tx_pop <= (kind == 1);
    tx_done <= (kind == 2);
    @(posedge clk);
    rx_end <= 1'b0;
    tx_pop <= 1'b0;
    tx_done <= 1'b0;
  endtask
  task automatic lines(input logic dp, input logic dm);
    @(posedge clk);
    dp_in <= dp;
    dm_in <= dm;
  endtask
endmodule // usb_host_model

/* dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, tx_data, rx_data;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [3:0] sel = 4'hf;
  logic rx_valid, rx_end, tx_pop, tx_done, dp_in, dm_in;
  logic tx_packet_ready, transceiver_off, pullup_connect, bus_reset;
  int n_errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  usb_ep_port i_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .tx_pop(tx_pop),
    .tx_data(tx_data), .tx_packet_ready(tx_packet_ready), .tx_done(tx_done),
    .dp_in(dp_in), .dm_in(dm_in), .transceiver_off(transceiver_off),
    .pullup_connect(pullup_connect), .bus_reset(bus_reset));
  usb_host_model i_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_pop(tx_pop), .tx_done(tx_done), .dp_in(dp_in), .dm_in(dm_in));
  ////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // request held until ack is sampled; bounded so a dead slave counts a mismatch
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ack, 1'b1);
      n_errors++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(1'b0, usb_ep_pkg::off_csr, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_txvc;
    wb(1'b1, usb_ep_pkg::off_txvc, 32'h100);
    chk({transceiver_off, pullup_connect}, 2'h2);
    wb(1'b1, usb_ep_pkg::off_txvc, 32'h200);
    chk({transceiver_off, pullup_connect}, 2'h1);
    // without sel[1] the transceiver bits must not move
    @(posedge clk);
    sel <= 4'h1;
    wb(1'b1, usb_ep_pkg::off_txvc, 32'h100);
    chk({transceiver_off, pullup_connect}, 2'h1);
    @(posedge clk);
    sel <= 4'hf;
    wb(1'b0, usb_ep_pkg::off_txvc, 32'h0);
    chk(rd, 32'h200);
  endtask
  task automatic t_rx;
    logic [7:0] b[3] = '{8'h5a, 8'hc3, 8'h01};
    foreach (b[k]) i_host.send_byte(b[k]);
    i_host.pulse(0);
    wb(1'b0, usb_ep_pkg::off_csr, 32'h0);
    chk(rd, (32'd3 << usb_ep_pkg::cnt_lsb) | 32'h2);
    foreach (b[k]) begin
      wb(1'b0, usb_ep_pkg::off_fifo, 32'h0);
      chk(rd, {24'h0, b[k]});
    end
    wb(1'b1, usb_ep_pkg::off_csr, 32'h0);
    wb(1'b0, usb_ep_pkg::off_csr, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_tx;
    wb(1'b1, usb_ep_pkg::off_fifo, 32'h1a5);
    wb(1'b1, usb_ep_pkg::off_fifo, 32'h3c);
    wb(1'b1, usb_ep_pkg::off_csr, 32'h12);
    chk({tx_packet_ready, tx_data}, 9'h1a5);
    // payload handed over: a further push is refused
    wb(1'b1, usb_ep_pkg::off_fifo, 32'hee);
    wb(1'b0, usb_ep_pkg::off_csr, 32'h0);
    chk(rd, (32'd2 << usb_ep_pkg::cnt_lsb) | 32'h10);
    i_host.pulse(1);
    @(posedge clk);
    chk(tx_data, 8'h3c);
    i_host.pulse(1);
    i_host.pulse(2);
    @(posedge clk);
    chk(tx_packet_ready, 1'b0);
  endtask
  task automatic t_se0;
    int i;
    i_host.send_byte(8'h77);
    i_host.lines(1'b0, 1'b0);
    for (i = 0; i < 8 && bus_reset !== 1'b1; i++) @(posedge clk);
    chk(bus_reset, 1'b1);
    i_host.lines(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    chk(bus_reset, 1'b0);
    // the bus reset must have emptied the fifo; both flags were already low before it and stay low
    wb(1'b0, usb_ep_pkg::off_csr, 32'h0);
    chk(rd, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_txvc();
    t_rx();
    t_tx();
    t_se0();
    results();
  end
endmodule // tb_top
